//--- hdl/otbt_regs.sv
// trim, curvature, sense control and battery trip register group
`timescale 1ns/1ns
module otbt_regs
(
	input  wire logic        mclk_i,          // system clock
	input  wire logic        rst_n_i,         // async reset, active low
	input  wire logic [7:0]  reg_addr_i,      // register address
	input  wire logic        reg_wr_i,        // write strobe
	input  wire logic [7:0]  reg_wdata_i,     // write data
	input  wire logic        reg_rd_i,        // read strobe
	output logic      [7:0]  reg_rdata_o,     // read data, registered
	input  wire logic [7:0]  fuse_trim_i,     // factory initial trim
	input  wire logic [6:0]  fuse_curv_i,     // factory curvature coeff
	input  wire logic [4:0]  fuse_gain_i,     // factory step gain
	input  wire logic        fuse_load_i,     // power-up recall pulse
	input  wire logic        conv_done_i,     // one conversion finished
	output logic             conv_start_o,    // start cycle pulse
	output logic             conv_busy_o,     // cycle in progress
	output logic      [12:0] trip_first_mv_o, // first trip level, mV
	output logic      [12:0] trip_second_mv_o,// second trip level, mV
	output logic             trip_first_ok_o, // first code defined
	output logic             trip_second_ok_o,// second code defined
	output logic             temp_sense_en_o, // sensing enable
	output logic             batt_sense_en_o, // battery-mode sensing
	output logic             batt_sense_rate_o,// 1: every minute
	output otbt_pkg::otbt_trim_t trim_o       // trim to the oscillator
);
	// register state and the two decoded selector codes
	logic [5:0] batt_trip_reg;         // both trip selectors
	logic [7:0] initial_osc_trim_reg;  // recalled initial trim
	logic [6:0] cold_curv_reg;         // recalled curvature coeff
	logic [4:0] step_gain_reg;         // recalled step gain
	logic [2:0] ctrl_reg;              // sense, battery sense, rate
	logic [2:0] trip_a;                // first selector code
	logic [2:0] trip_b;                // second selector code
	// conversion cycle: idle, first and second conversion
	typedef enum logic [1:0] {S_IDLE, S_CONV1, S_CONV2} otbt_state_t;
	otbt_state_t state_reg;            // conversion cycle state

	// first trip table
	// levels in millivolts; code 7 has no level and returns zero
	function automatic otbt_pkg::otbt_mv_t trip_first_mv(input logic [2:0] c);
		case (c)
			3'h0:    trip_first_mv = 13'd2125;
			3'h1:    trip_first_mv = 13'd2295;
			3'h2:    trip_first_mv = 13'd2550;
			3'h3:    trip_first_mv = 13'd2805;
			3'h4:    trip_first_mv = 13'd3060;
			3'h5:    trip_first_mv = 13'd4250;
			3'h6:    trip_first_mv = 13'd4675;
			default: trip_first_mv = 13'd0;
		endcase
	endfunction

	// second trip table
	// levels in millivolts; code 7 has no level and returns zero
	function automatic otbt_pkg::otbt_mv_t trip_second_mv(input logic [2:0] c);
		case (c)
			3'h0:    trip_second_mv = 13'd1875;
			3'h1:    trip_second_mv = 13'd2025;
			3'h2:    trip_second_mv = 13'd2250;
			3'h3:    trip_second_mv = 13'd2475;
			3'h4:    trip_second_mv = 13'd2700;
			3'h5:    trip_second_mv = 13'd3750;
			3'h6:    trip_second_mv = 13'd4125;
			default: trip_second_mv = 13'd0;
		endcase
	endfunction

	// split the shared register into its two selector codes
	assign trip_a = batt_trip_reg[otbt_pkg::POS_TRIP_FIRST +: 3];
	assign trip_b = batt_trip_reg[otbt_pkg::POS_TRIP_SECOND +: 3];

	// trip selectors, fully writable, each independent
	// both fields land together; neither limits the other
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			batt_trip_reg <= otbt_pkg::RST_BATT_TRIP;
		else if (reg_wr_i && reg_addr_i == otbt_pkg::OFS_BATT_TRIP)
			batt_trip_reg <= reg_wdata_i[5:0];
	end

	// factory values recalled at power-up, never written by software
	// no write path reaches these registers, so software cannot alter them
	// a repeated recall pulse reloads whatever values the fuse inputs present
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			initial_osc_trim_reg <= 8'h00;
			cold_curv_reg        <= 7'h00;
			step_gain_reg        <= 5'h00;
		end
		else if (fuse_load_i)
		begin
			initial_osc_trim_reg <= fuse_trim_i;
			cold_curv_reg        <= fuse_curv_i;
			step_gain_reg        <= fuse_gain_i;
		end
	end

	// control bits: only the upper three take write data
	// the lower five bits read back from the recalled step gain
	// reset clears all three sensing controls
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ctrl_reg <= otbt_pkg::RST_CTRL;
		else if (reg_wr_i && reg_addr_i == otbt_pkg::OFS_SENSE_CTRL)
			ctrl_reg <= reg_wdata_i[7:5];
	end

	// conversion cycle: two conversions per enable
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state_reg <= S_IDLE;
		else
			case (state_reg)
				// wait for software to set the sense enable
				S_IDLE:  if (conv_start_o) state_reg <= S_CONV1;
				// first conversion running
				S_CONV1: if (conv_done_i) state_reg <= S_CONV2;
				// second conversion; its end closes the cycle
				S_CONV2: if (conv_done_i) state_reg <= S_IDLE;
				// unused encoding, recover to idle
				default: state_reg <= S_IDLE;
			endcase
	end

	// start when software writes a one to the sense enable
	// a rewrite while busy starts no new cycle; the running cycle finishes first
	assign conv_start_o = reg_wr_i
		&& reg_addr_i == otbt_pkg::OFS_SENSE_CTRL
		&& reg_wdata_i[otbt_pkg::POS_TEMP_SENSE]
		&& state_reg == S_IDLE;
	// busy from the edge that takes the start until the second done
	assign conv_busy_o = state_reg != S_IDLE;

	// registered read data, unmapped reads as zero
	// read-only registers answer with their recalled values
	// a read has no side effect on any register
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
			case (reg_addr_i)
				otbt_pkg::OFS_BATT_TRIP:     reg_rdata_o <= {2'b00, batt_trip_reg};
				otbt_pkg::OFS_INIT_OSC_TRIM: reg_rdata_o <= initial_osc_trim_reg;
				otbt_pkg::OFS_COLD_CURV:     reg_rdata_o <= {1'b0, cold_curv_reg};
				otbt_pkg::OFS_SENSE_CTRL:    reg_rdata_o <= {ctrl_reg, step_gain_reg};
				default:                     reg_rdata_o <= 8'h00;
			endcase
	end

	// decoded trip levels
	// code 7 drops the ok flag so users can ignore the level
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			trip_first_mv_o  <= 13'd0;
			trip_second_mv_o <= 13'd0;
			trip_first_ok_o  <= 1'b0;
			trip_second_ok_o <= 1'b0;
		end
		else
		begin
			trip_first_mv_o  <= trip_first_mv(trip_a);
			trip_second_mv_o <= trip_second_mv(trip_b);
			trip_first_ok_o  <= trip_a != otbt_pkg::TRIP_RESERVED;
			trip_second_ok_o <= trip_b != otbt_pkg::TRIP_RESERVED;
		end
	end

	// control levels straight from the register
	assign temp_sense_en_o   = ctrl_reg[2];
	assign batt_sense_en_o   = ctrl_reg[1];
	assign batt_sense_rate_o = ctrl_reg[0];

	// oscillator trim from initial values; frozen while the sense enable is on
	// the last value holds while sensing runs, so the oscillator sees
	// no step back to the initial trims in mid-cycle
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			trim_o <= '0;
		else if (!ctrl_reg[2])
		begin
			// 32 minus code gives +32..-31 ppm
			trim_o.analog_ppm     <= 7'sd32
				- $signed({1'b0, initial_osc_trim_reg[5:0]});
			// skip lowers, insert raises frequency
			// disabled and zero codes both leave the pulse count alone
			trim_o.digital_insert <= initial_osc_trim_reg[7:6]
				== otbt_pkg::DIG_TRIM_PLUS;
			trim_o.digital_skip   <= initial_osc_trim_reg[7:6]
				== otbt_pkg::DIG_TRIM_MINUS;
		end
	end
endmodule

//--- hdl/otbt_pkg.sv
// package: offsets, field layouts and reset values of the trim/trip registers
package otbt_pkg;
	localparam logic [7:0] OFS_BATT_TRIP      = 8'h0a; // trip selector register
	localparam logic [7:0] OFS_INIT_OSC_TRIM  = 8'h0b; // initial trim, read only
	localparam logic [7:0] OFS_COLD_CURV      = 8'h0c; // curvature coefficient
	localparam logic [7:0] OFS_SENSE_CTRL     = 8'h0d; // sense control / step gain
	localparam int         POS_TRIP_FIRST     = 3;     // first trip field lsb
	localparam int         POS_TRIP_SECOND    = 0;     // second trip field lsb
	localparam int         POS_TEMP_SENSE     = 7;     // temp sense enable bit
	localparam int         POS_BSE            = 6;     // battery sense enable bit
	localparam int         POS_BSR            = 5;     // battery sense rate bit
	localparam logic [7:0] CTRL_WR_MASK       = 8'he0; // writable control bits
	localparam logic [2:0] TRIP_RESERVED      = 3'h7;  // undefined trip code
	localparam logic [5:0] RST_BATT_TRIP      = 6'h00; // trip selectors at reset
	localparam logic [2:0] RST_CTRL           = 3'h0;  // all sensing off at reset
	localparam logic [1:0] DIG_TRIM_OFF       = 2'h0;  // digital trim off
	localparam logic [1:0] DIG_TRIM_PLUS      = 2'h1;  // +30.5 ppm
	localparam logic [1:0] DIG_TRIM_ZERO      = 2'h2;  // 0 ppm
	localparam logic [1:0] DIG_TRIM_MINUS     = 2'h3;  // -30.5 ppm
	// trip level in millivolts per code
	typedef logic [12:0] otbt_mv_t;
	// decoded trim applied to the oscillator
	typedef struct packed {
		logic              digital_skip;   // remove pulses (slow down)
		logic              digital_insert; // add pulses (speed up)
		logic signed [6:0] analog_ppm;     // analog trim in ppm, +32..-31
	} otbt_trim_t;
endpackage

//--- bench/otbt_regs_sva.sv
// checker on the ports of the trim and trip register group
`timescale 1ns/1ns
module otbt_chk
(
	input wire logic        mclk_i,           // clock
	input wire logic        rst_n_i,          // reset, low
	input wire logic [7:0]  reg_addr_i,       // address
	input wire logic        reg_wr_i,         // write strobe
	input wire logic [7:0]  reg_wdata_i,      // write data
	input wire logic        conv_start_o,     // start pulse
	input wire logic        conv_busy_o,      // cycle busy
	input wire logic [12:0] trip_first_mv_o,  // first level
	input wire logic [12:0] trip_second_mv_o, // second level
	input wire logic        trip_first_ok_o,  // first defined
	input wire logic        trip_second_ok_o, // second defined
	input wire logic        temp_sense_en_o,  // bit 7
	input wire logic        batt_sense_en_o,  // bit 6
	input wire logic        batt_sense_rate_o,// bit 5
	input wire otbt_pkg::otbt_trim_t trim_o   // oscillator trim
);
	wire ctl_wr = reg_wr_i && reg_addr_i == 8'h0d; // control write
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	sense_en_a: assert property (
		ctl_wr |=> temp_sense_en_o == $past(reg_wdata_i[7]))
		else $error("sense enable not taken");
	ctrl_bse_a: assert property (
		ctl_wr |=> batt_sense_en_o == $past(reg_wdata_i[6]))
		else $error("battery sense not taken");
	ctrl_bsr_a: assert property (
		ctl_wr |=> batt_sense_rate_o == $past(reg_wdata_i[5]))
		else $error("battery rate not taken");
	first_level_a: assert property (
		trip_first_ok_o |-> trip_first_mv_o inside {13'd2125, 13'd2295,
		13'd2550, 13'd2805, 13'd3060, 13'd4250, 13'd4675})
		else $error("first trip level off table");
	second_level_a: assert property (
		trip_second_ok_o |-> trip_second_mv_o inside {13'd1875, 13'd2025,
		13'd2250, 13'd2475, 13'd2700, 13'd3750, 13'd4125})
		else $error("second trip level off table");
	trip_rsvd_a: assert property (
		reg_wr_i && reg_addr_i == 8'h0a && reg_wdata_i[5:3] == 3'h7
		|-> ##[1:2] !trip_first_ok_o && trip_first_mv_o == 13'h0000)
		else $error("reserved trip code accepted");
	conv_start_a: assert property (
		ctl_wr && reg_wdata_i[7] && !conv_busy_o |-> conv_start_o ##1 conv_busy_o)
		else $error("conversion cycle not started");
	analog_range_a: assert property (
		trim_o.analog_ppm >= -31 && trim_o.analog_ppm <= 32)
		else $error("analog trim out of range");
endmodule
bind otbt_regs otbt_chk i_chk
(
	.mclk_i            (mclk_i),
	.rst_n_i           (rst_n_i),
	.reg_addr_i        (reg_addr_i),
	.reg_wr_i          (reg_wr_i),
	.reg_wdata_i       (reg_wdata_i),
	.conv_start_o      (conv_start_o),
	.conv_busy_o       (conv_busy_o),
	.trip_first_mv_o   (trip_first_mv_o),
	.trip_second_mv_o  (trip_second_mv_o),
	.trip_first_ok_o   (trip_first_ok_o),
	.trip_second_ok_o  (trip_second_ok_o),
	.temp_sense_en_o   (temp_sense_en_o),
	.batt_sense_en_o   (batt_sense_en_o),
	.batt_sense_rate_o (batt_sense_rate_o),
	.trim_o            (trim_o)
);

//--- bench/testbench.sv
// self-checking bench of the trim and trip register group
`timescale 1ns/1ns
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
	err_count++; $display("wrong value %s exp %0h got %0h", n, e, a); end end
module testbench;
	logic        mclk_i = 1'b0;   // clock
	logic        rst_n_i = 1'b0;  // reset, low
	logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, fuse_trim_i = 8'h00;
	logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, fuse_load_i = 1'b0;
	logic        conv_done_i = 1'b0; // conversion done
	logic [6:0]  fuse_curv_i = 7'h46; // factory coefficient
	logic [4:0]  fuse_gain_i = 5'h13; // factory gain
	logic [7:0]  reg_rdata_o;     // read data
	logic [12:0] trip_first_mv_o, trip_second_mv_o;
	logic        conv_start_o, conv_busy_o, trip_first_ok_o, trip_second_ok_o;
	logic        temp_sense_en_o, batt_sense_en_o, batt_sense_rate_o;
	otbt_pkg::otbt_trim_t trim_o; // oscillator trim
	wire  [2:0]  ctl = {temp_sense_en_o, batt_sense_en_o, batt_sense_rate_o};
	int          err_count = 0, samples_checked = 0;
	int          lv1[7] = '{2125, 2295, 2550, 2805, 3060, 4250, 4675};
	int          lv2[7] = '{1875, 2025, 2250, 2475, 2700, 3750, 4125};
	otbt_regs i_dut
	(
		.mclk_i            (mclk_i),
		.rst_n_i           (rst_n_i),
		.reg_addr_i        (reg_addr_i),
		.reg_wr_i          (reg_wr_i),
		.reg_wdata_i       (reg_wdata_i),
		.reg_rd_i          (reg_rd_i),
		.reg_rdata_o       (reg_rdata_o),
		.fuse_trim_i       (fuse_trim_i),
		.fuse_curv_i       (fuse_curv_i),
		.fuse_gain_i       (fuse_gain_i),
		.fuse_load_i       (fuse_load_i),
		.conv_done_i       (conv_done_i),
		.conv_start_o      (conv_start_o),
		.conv_busy_o       (conv_busy_o),
		.trip_first_mv_o   (trip_first_mv_o),
		.trip_second_mv_o  (trip_second_mv_o),
		.trip_first_ok_o   (trip_first_ok_o),
		.trip_second_ok_o  (trip_second_ok_o),
		.temp_sense_en_o   (temp_sense_en_o),
		.batt_sense_en_o   (batt_sense_en_o),
		.batt_sense_rate_o (batt_sense_rate_o),
		.trim_o            (trim_o)
	);
	always #5 mclk_i = ~mclk_i;
	// one edge, then settle
	task automatic tick; @(posedge mclk_i) #1; endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		tick();
		{reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
		tick();
		reg_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		tick();
		{reg_addr_i, reg_rd_i} = {a, 1'b1};
		tick();
		reg_rd_i = 1'b0;
		tick();
		`CHK("read data", e, reg_rdata_o)
	endtask
	// factory recall pulse
	task automatic fuse(input logic [7:0] t);
		tick();
		{fuse_trim_i, fuse_load_i} = {t, 1'b1};
		tick();
		fuse_load_i = 1'b0;
		repeat (2) tick();
	endtask
	task automatic t_factory;
		`CHK("ctl", 3'h0, ctl)
		rd(8'h0d, 8'h00);
		fuse(8'h45);
		wr(8'h0b, 8'hff);
		wr(8'h0c, 8'hff);
		rd(8'h0b, 8'h45);
		rd(8'h0c, 8'h46);
		rd(8'h0d, 8'h13);
		rd(8'h20, 8'h00);
		$display("t_factory done");
	endtask
	task automatic t_trim;
		for (int i = 0; i < 4; i++)
		begin
			fuse({i[1:0], i[1] ? 6'h3f : 6'h00});
			`CHK("insert", i == 1, trim_o.digital_insert)
			`CHK("skip", i == 3, trim_o.digital_skip)
			`CHK("analog", i[1] ? -7'sd31 : 7'sd32, trim_o.analog_ppm)
		end
		$display("t_trim done");
	endtask
	task automatic t_trip;
		for (int i = 0; i < 7; i++)
		begin
			wr(8'h0a, {2'b00, i[2:0], 3'(6 - i)});
			repeat (2) tick();
			`CHK("first", lv1[i], trip_first_mv_o)
			`CHK("second", lv2[6 - i], trip_second_mv_o)
			`CHK("defined", 2'b11, {trip_first_ok_o, trip_second_ok_o})
		end
		wr(8'h0a, 8'h3f);
		repeat (2) tick();
		`CHK("reserved", 2'b00, {trip_first_ok_o, trip_second_ok_o})
		`CHK("no level", 26'h0, {trip_first_mv_o, trip_second_mv_o})
		$display("t_trip done");
	endtask
	// sensing cycle, then the trims follow the recall once it is off
	task automatic t_sense;
		tick();
		{reg_addr_i, reg_wdata_i, reg_wr_i} = {8'h0d, 8'hff, 1'b1};
		#1 `CHK("start", 1'b1, conv_start_o)
		tick();
		reg_wr_i = 1'b0;
		`CHK("busy", 1'b1, conv_busy_o)
		`CHK("ctl", 3'h7, ctl)
		tick();
		{reg_addr_i, reg_wdata_i, reg_wr_i} = {8'h0d, 8'hff, 1'b1};
		#1 `CHK("restart", 1'b0, conv_start_o)
		tick();
		reg_wr_i = 1'b0;
		rd(8'h0d, 8'hf3);
		for (int k = 0; k < 2; k++)
		begin
			`CHK("busy", 1'b1, conv_busy_o)
			tick();
			conv_done_i = 1'b1;
			tick();
			conv_done_i = 1'b0;
		end
		tick();
		`CHK("idle", 1'b0, conv_busy_o)
		wr(8'h0d, 8'h20);
		`CHK("ctl", 3'h1, ctl)
		fuse(8'h60);
		`CHK("insert", 1'b1, trim_o.digital_insert)
		`CHK("skip", 1'b0, trim_o.digital_skip)
		`CHK("analog", 7'sd0, trim_o.analog_ppm)
		$display("t_sense done");
	endtask
	// reset in mid-run clears the control bits and abandons a cycle
	task automatic t_reset;
		wr(8'h0d, 8'hc0);
		`CHK("ctl", 3'h6, ctl)
		`CHK("busy", 1'b1, conv_busy_o)
		tick();
		rst_n_i = 1'b0;
		tick();
		`CHK("ctl", 3'h0, ctl)
		`CHK("busy", 1'b0, conv_busy_o)
		rst_n_i = 1'b1;
		rd(8'h0d, 8'h00);
		$display("t_reset done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge mclk_i);
		#1 rst_n_i = 1'b1;
		t_factory();
		t_trim();
		t_trip();
		t_sense();
		t_reset();
		finish_test();
	end
	// hang guard, well beyond the hundred or so cycles used
	initial
	begin
		#20000;
		err_count++;
		finish_test();
	end
endmodule
